// ---- bench/test_uart_baud_gen_control.sv ----
// test_uart_baud_gen_control: directed checks of control register, divider, tx and rx.
// assumes: ubg_pkg compiled first; far end modelled by ubg_far_end.
`timescale 1ns/1ps
module test_uart_baud_gen_control;
	import ubg_pkg::*;
	logic       clk_sys, nrst, sfrWr, sfrRd, sendReq, baudTick, portEnable;
	logic       txLoad, txShiftDone, rxValid, rxFull;
	logic [7:0] sfrAddr, sfrWrData, sendByte, sfrRdData, txByte, rxByte;
	int         err_count, check_count;
	ubg_baud_ctrl ubg_baud_ctrl_i (.clk_sys(clk_sys), .nrst(nrst), .sfrAddr(sfrAddr),
		.sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
		.baudTick(baudTick), .portEnable(portEnable), .txLoad(txLoad), .txByte(txByte),
		.txShiftDone(txShiftDone), .rxValid(rxValid), .rxByte(rxByte), .rxFull(rxFull));
	ubg_far_end ubg_far_end_i (.clk_sys(clk_sys), .nrst(nrst), .txLoad(txLoad),
		.txShiftDone(txShiftDone), .sendReq(sendReq), .sendByte(sendByte),
		.rxValid(rxValid), .rxByte(rxByte));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfrAddr <= a;
		sfrWrData <= d;
		sfrWr <= 1'b1;
		@(posedge clk_sys);
		sfrWr <= 1'b0;
	endtask
	task sfr_rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		sfrAddr <= a;
		sfrRd <= 1'b1;
		@(posedge clk_sys);
		sfrRd <= 1'b0;
		#1 v = sfrRdData;
	endtask
	// which: 0 waits for a tick, 1 for a load; n counts cycles
	task wait_on(input int which, output int n);
		n = 0;
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while ((which == 0 ? baudTick : txLoad) !== 1'b1 && n < 200);
		if (n >= 200) begin
			err_count++;
			finish_test;
		end
	endtask
	task count_pulses(input int cyc, output int ticks, output int loads);
		ticks = 0;
		loads = 0;
		repeat (cyc) begin
			@(posedge clk_sys);
			#1 ticks += (baudTick === 1'b1);
			loads += (txLoad === 1'b1);
		end
	endtask
	task t_regs;
		logic [7:0] v;
		sfr_rd(BAUD_CTRL_ADDR, v);
		check(v, 8'h00);
		check(8'(portEnable), 8'h00);
		sfr_wr(BAUD_CTRL_ADDR, 8'h43);
		sfr_rd(BAUD_CTRL_ADDR, v);
		check(v, 8'h43);
		sfr_rd(8'h10, v);
		check(v, 8'h00);
	endtask
	task automatic t_prescale;
		int nTab[4] = '{12, 4, 48, 1};
		int n;
		for (int s = 0; s < 4; s++) begin
			sfr_wr(BAUD_CTRL_ADDR, 8'h40 | 8'(s));
			wait_on(0, n);
			wait_on(0, n);
			check(8'(n), 8'(nTab[s]));
			check(8'(portEnable), 8'h01);
		end
	endtask
	task t_stop_tx;
		int t;
		int l;
		int n;
		sfr_wr(BAUD_CTRL_ADDR, 8'h00);
		sfr_wr(SER_BUF_ADDR, 8'hA5);
		count_pulses(60, t, l);
		check(8'(t), 8'h00);
		check(8'(l), 8'h00);
		check(8'(portEnable), 8'h00);
		sfr_wr(BAUD_CTRL_ADDR, 8'h40);
		wait_on(1, n);
		check(txByte, 8'hA5);
		count_pulses(6, t, l);
		sfr_wr(SER_BUF_ADDR, 8'h5A);
		wait_on(1, n);
		check(8'(n), 8'h01);
		check(txByte, 8'h5A);
		sfr_wr(SER_BUF_ADDR, 8'h77);
		wait_on(1, n);
		check(txByte, 8'h77);
	endtask
	task automatic t_rx;
		logic [7:0] rxTab[4] = '{8'h3C, 8'hC3, 8'h96, 8'h69};
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			sendReq <= 1'b1;
			sendByte <= rxTab[i];
		end
		@(posedge clk_sys);
		sendReq <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 check(8'(rxFull), 8'h01);
		for (int i = 0; i < 3; i++) begin
			sfr_rd(SER_BUF_ADDR, v);
			check(v, rxTab[i]);
		end
		sfr_rd(SER_BUF_ADDR, v);
		check(v, 8'h00);
		check(8'(rxFull), 8'h00);
	endtask
	initial begin
		{nrst, sfrWr, sfrRd, sendReq} = 4'h0;
		{sfrAddr, sfrWrData, sendByte} = 24'h000000;
		err_count = 0;
		check_count = 0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		t_regs;
		t_prescale;
		t_stop_tx;
		t_rx;
		finish_test;
	end
endmodule

// ---- bench/ubg_far_end.sv ----
// ubg_far_end: remote serial end, finishes shifts and injects received bytes.
// assumes: one system clock; the bench asks for one byte per cycle that sendReq is high.
`timescale 1ns/1ps
module ubg_far_end #(
	parameter int DLY = 3
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	// transmit side
	input  wire logic       txLoad,
	output logic            txShiftDone,
	// receive side
	input  wire logic       sendReq,
	input  wire logic [7:0] sendByte,
	output logic            rxValid,
	output logic      [7:0] rxByte
);
	int shiftCnt_q;
	always_ff @(posedge clk_sys) begin
		txShiftDone <= 1'b0;
		if (!nrst) begin
			shiftCnt_q <= 0;
		end else if (txLoad) begin
			shiftCnt_q <= DLY;
		end else if (shiftCnt_q > 0) begin
			shiftCnt_q  <= shiftCnt_q - 1;
			txShiftDone <= (shiftCnt_q == 1);
		end
	end
	// idle line toggles so a stale byte is never mistaken for data
	always_ff @(posedge clk_sys) begin
		rxValid <= sendReq && nrst;
		rxByte  <= !nrst ? 8'h5A : (sendReq ? sendByte : ~rxByte);
	end
endmodule

// ---- src/ubg_baud_ctrl.sv ----
// ubg_baud_ctrl: baud generator control register, prescaler and data buffer of the
// second serial port.
// assumes: processor side issues single-cycle sfr strobes; serial shifter lives outside.
`timescale 1ns/1ps
module ubg_baud_ctrl
	import ubg_pkg::*;
#(
	parameter int RX_DEPTH = RX_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	// sfr access
	input  wire logic [7:0] sfrAddr,
	input  wire logic       sfrWr,
	input  wire logic       sfrRd,
	input  wire logic [7:0] sfrWrData,
	output logic      [7:0] sfrRdData,
	// baud timing
	output logic            baudTick,
	output logic            portEnable,
	// transmit shifter
	output logic            txLoad,
	output logic      [7:0] txByte,
	input  wire logic       txShiftDone,
	// receive shifter
	input  wire logic       rxValid,
	input  wire logic [7:0] rxByte,
	output logic            rxFull
);
	ubg_ctrl_t     ctrl_q;
	logic [5:0]    preCnt_q;
	logic [7:0]    hold_q;
	ubg_tx_state_t txState_q;
	logic [7:0]    fifoHead;
	logic          fifoNotEmpty;
	logic          fifoFull;
	logic          wrCtrl;
	logic          wrBuf;
	logic          rdBuf;
	logic          rdCtrl;
	logic          txPend_q;
	logic          steadyRun_q;

	// one address compare for every strobe keeps the map in a single place
	function automatic logic sfr_hit(input logic strobe, input logic [7:0] addr,
			input logic [7:0] target);
		sfr_hit = strobe && (addr == target);
	endfunction

	assign wrCtrl = sfr_hit(sfrWr, sfrAddr, BAUD_CTRL_ADDR);
	assign wrBuf  = sfr_hit(sfrWr, sfrAddr, SER_BUF_ADDR);
	assign rdBuf  = sfr_hit(sfrRd, sfrAddr, SER_BUF_ADDR);
	assign rdCtrl = sfr_hit(sfrRd, sfrAddr, BAUD_CTRL_ADDR);

	// reserved bits are simply not stored, so they cannot read back set
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ctrl_q <= ubg_ctrl_t'({BAUD_CTRL_RESET[RUN_BIT], BAUD_CTRL_RESET[PS_LSB +: 2]});
		end else if (wrCtrl) begin
			ctrl_q.run      <= sfrWrData[RUN_BIT];
			ctrl_q.prescale <= sfrWrData[PS_LSB +: 2];
		end
	end

	// divider restarts on disable so the first tick is a full period
	always_ff @(posedge clk_sys) begin
		if (!nrst || !ctrl_q.run) begin
			preCnt_q <= 6'h00;
			baudTick <= 1'b0;
		end else if (preCnt_q >= prescale_count(ctrl_q.prescale) - 6'h01) begin
			preCnt_q <= 6'h00;
			baudTick <= 1'b1;
		end else begin
			preCnt_q <= preCnt_q + 6'h01;
			baudTick <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) portEnable <= 1'b0;
		else portEnable <= ctrl_q.run;
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) hold_q <= 8'h00;
		else if (wrBuf) hold_q <= sfrWrData;
	end

	// one held byte plus one in the shifter; a write while held overwrites it
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			txState_q <= TX_IDLE;
			txLoad    <= 1'b0;
			txByte    <= 8'h00;
		end else begin
			txLoad <= 1'b0;
			unique case (txState_q)
				TX_IDLE: if (wrBuf) txState_q <= TX_HELD;
				TX_HELD: if (ctrl_q.run) begin
					txLoad    <= 1'b1;
					txByte    <= hold_q;
					txState_q <= TX_SHIFT;
				end
				TX_SHIFT: if (txShiftDone) txState_q <= (wrBuf || txPend_q) ? TX_HELD : TX_IDLE;
				default: txState_q <= TX_IDLE;
			endcase
		end
	end

	// a byte written while the shifter is busy waits for the next free slot
	always_ff @(posedge clk_sys) begin
		if (!nrst) txPend_q <= 1'b0;
		else if (txState_q == TX_SHIFT && txShiftDone) txPend_q <= 1'b0;
		else if (wrBuf && (txState_q == TX_SHIFT || (txState_q == TX_HELD && ctrl_q.run)))
			txPend_q <= 1'b1;
	end

	ubg_rx_fifo #(
		.DEPTH (RX_DEPTH)
	) u_rx_fifo (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.push     (rxValid && ctrl_q.run),
		.pushData (rxByte),
		.pop      (rdBuf),
		.headData (fifoHead),
		.notEmpty (fifoNotEmpty),
		.full     (fifoFull)
	);

	always_ff @(posedge clk_sys) begin
		if (!nrst) rxFull <= 1'b0;
		else rxFull <= fifoFull;
	end

	// read data is registered: valid the cycle after the read strobe
	always_ff @(posedge clk_sys) begin
		if (!nrst) sfrRdData <= 8'h00;
		else if (rdCtrl)
			sfrRdData <= {1'b0, ctrl_q.run, 4'h0, ctrl_q.prescale};
		else if (rdBuf) sfrRdData <= fifoNotEmpty ? fifoHead : 8'h00;
		else sfrRdData <= 8'h00;
	end

	logic [5:0] tickGap_q;
	always_ff @(posedge clk_sys) begin
		if (!nrst || !ctrl_q.run || baudTick) tickGap_q <= 6'h00;
		else tickGap_q <= tickGap_q + 6'h01;
	end

	// a period is only judged when no control write fell inside it
	always_ff @(posedge clk_sys) begin
		if (!nrst || wrCtrl) steadyRun_q <= 1'b0;
		else if (baudTick) steadyRun_q <= 1'b1;
	end

	sequence s_ctrl_rd;
		rdCtrl;
	endsequence

	sequence s_buf_wr_busy;
		wrBuf && txState_q == TX_SHIFT && !txShiftDone;
	endsequence

	sequence s_done_pending;
		txState_q == TX_SHIFT && txShiftDone && txPend_q;
	endsequence

	a_no_tick_off: assert property (@(posedge clk_sys) disable iff (!nrst)
		!ctrl_q.run |=> !baudTick) else $error("baud tick while generator off");
	a_port_follow: assert property (@(posedge clk_sys) disable iff (!nrst)
		1'b1 |=> portEnable == $past(ctrl_q.run)) else $error("port enable lags run bit");
	a_div_period: assert property (@(posedge clk_sys) disable iff (!nrst)
		baudTick && steadyRun_q |-> tickGap_q == prescale_count(ctrl_q.prescale) - 6'h01)
		else $error("baud tick spacing wrong");
	a_div_max: assert property (@(posedge clk_sys) disable iff (!nrst)
		tickGap_q <= DIV48_CNT) else $error("prescaler overran");
	a_bit7_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_ctrl_rd |=> !sfrRdData[7]) else $error("reserved bit seven read as one");
	a_mid_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_ctrl_rd |=> sfrRdData[5:2] == 4'h0) else $error("reserved bits read nonzero");
	a_tx_load: assert property (@(posedge clk_sys) disable iff (!nrst)
		txLoad |-> txByte == $past(hold_q) && $past(ctrl_q.run)) else $error("bad transmit load");
	a_rx_head: assert property (@(posedge clk_sys) disable iff (!nrst)
		rdBuf && fifoNotEmpty |=> sfrRdData == $past(fifoHead))
		else $error("fifo head not returned");

	// reset check stays live while reset is held, so it has no disable clause
	a_reset_quiet: assert property (@(posedge clk_sys)
		!nrst |=> !baudTick && !portEnable && !txLoad && sfrRdData == 8'h00)
		else $error("outputs not cleared by reset");
	a_ctrl_write: assert property (@(posedge clk_sys) disable iff (!nrst)
		wrCtrl |=> ctrl_q.run == $past(sfrWrData[RUN_BIT]) &&
			ctrl_q.prescale == $past(sfrWrData[PS_LSB +: 2]))
		else $error("control write not stored");
	a_tick_single: assert property (@(posedge clk_sys) disable iff (!nrst)
		baudTick && ctrl_q.prescale != PS_DIV1 |=> !baudTick)
		else $error("baud tick wider than one cycle");
	a_load_off: assert property (@(posedge clk_sys) disable iff (!nrst)
		!ctrl_q.run |=> !txLoad)
		else $error("transmit load while generator off");
	// with the generator stopped nothing may enter the receive store
	a_rx_gated: assert property (@(posedge clk_sys) disable iff (!nrst)
		!ctrl_q.run && !rdBuf |=> fifoNotEmpty == $past(fifoNotEmpty) &&
			fifoFull == $past(fifoFull))
		else $error("receive store changed while off");
	a_held_load: assert property (@(posedge clk_sys) disable iff (!nrst)
		txState_q == TX_HELD && ctrl_q.run |=> txLoad)
		else $error("held byte not loaded");
	a_pend_set: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_buf_wr_busy |=> txPend_q)
		else $error("byte written during shift not kept");
	a_pend_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_done_pending |=> txState_q == TX_HELD)
		else $error("kept byte not queued after shift");
	a_rd_empty: assert property (@(posedge clk_sys) disable iff (!nrst)
		rdBuf && !fifoNotEmpty |=> sfrRdData == 8'h00)
		else $error("empty store read not zero");
endmodule

// ---- src/ubg_pkg.sv ----
// ubg_pkg: register map, field layout and timing constants for the baud generator control.
// assumes: 8-bit special function register access; one 10 MHz system clock.
package ubg_pkg;

	localparam logic [7:0] BAUD_CTRL_ADDR    = 8'hAC;
	localparam logic [7:0] SER_BUF_ADDR      = 8'hD3;
	localparam logic [7:0] BAUD_CTRL_RESET   = 8'h00;
	localparam int         RUN_BIT           = 6;
	localparam int         PS_LSB            = 0;
	localparam logic [7:0] BAUD_CTRL_RD_MASK = 8'h43;

	localparam logic [1:0] PS_DIV12 = 2'h0;
	localparam logic [1:0] PS_DIV4  = 2'h1;
	localparam logic [1:0] PS_DIV48 = 2'h2;
	localparam logic [1:0] PS_DIV1  = 2'h3;

	localparam logic [5:0] DIV12_CNT = 6'h0C;
	localparam logic [5:0] DIV4_CNT  = 6'h04;
	localparam logic [5:0] DIV48_CNT = 6'h30;
	localparam logic [5:0] DIV1_CNT  = 6'h01;

	localparam int RX_FIFO_DEPTH = 3;

	typedef struct packed {
		logic       run;
		logic [1:0] prescale;
	} ubg_ctrl_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_HELD = 2'b01,
		TX_SHIFT = 2'b11
	} ubg_tx_state_t;

	function automatic logic [5:0] prescale_count(input logic [1:0] sel);
		unique case (sel)
			PS_DIV12: prescale_count = DIV12_CNT;
			PS_DIV4:  prescale_count = DIV4_CNT;
			PS_DIV48: prescale_count = DIV48_CNT;
			PS_DIV1:  prescale_count = DIV1_CNT;
		endcase
	endfunction

endpackage

// ---- src/ubg_rx_fifo.sv ----
// ubg_rx_fifo: small receive byte store with registered read data.
// assumes: nothing of the caller; a push when full and a pop when empty are ignored.
`timescale 1ns/1ps
module ubg_rx_fifo #(
	parameter int DEPTH = 3
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	// write side
	input  wire logic       push,
	input  wire logic [7:0] pushData,
	// read side
	input  wire logic       pop,
	output logic      [7:0] headData,
	output logic            notEmpty,
	output logic            full
);
	localparam int AW = $clog2(DEPTH + 1);
	logic [7:0]    mem_q [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW-1:0] count_q;

	function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
		wrap = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push && !full) wrPtr_q <= wrap(wrPtr_q);
			if (pop && notEmpty) rdPtr_q <= wrap(rdPtr_q);
			if ((push && !full) && !(pop && notEmpty)) count_q <= count_q + AW'(1);
			else if (!(push && !full) && (pop && notEmpty)) count_q <= count_q - AW'(1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push && !full) mem_q[wrPtr_q] <= pushData;
	end

	// registered head keeps the read path off the memory array
	always_ff @(posedge clk_sys) begin
		if (!nrst) headData <= 8'h00;
		else headData <= mem_q[(pop && notEmpty) ? wrap(rdPtr_q) : rdPtr_q];
	end

	assign notEmpty = (count_q != '0);
	assign full     = (count_q == AW'(DEPTH));
endmodule
